// *** rtl/cpubt_core.sv ***
`timescale 1ns/1ps
// Contract
// - External moves address by pointer or data pointer
// - Accumulator alone sources or sinks external data
// - Table load reads code at acc plus data pointer
// - Table load reads code at acc plus next
// - Table loads only read code memory
// - Low bit space is RAM, high is special
// - Bit target comes directly from the instruction
// - Port bit write changes that line only
// - Carry is bit accumulator and directly addressable
// - Move, set, clear, invert, and, or bits
// - No exclusive-or on single bits
// - Bit branches taken on one or zero
// - Test-and-clear branch jumps and clears bit
// - Every status word bit is bit-addressable
// - Taken branch adds signed offset to next address
// - External move takes two cycles, no fetch in the second
// - Machine cycle is twelve oscillator periods
module cpubt_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] code_addr,
	output logic code_rd,
	input wire logic [7:0] code_rdata,
	output logic [15:0] xdata_addr,
	output logic [7:0] xdata_wdata,
	output logic xdata_rd,
	output logic xdata_wr,
	input wire logic [7:0] xdata_rdata,
	input wire logic [31:0] port_in,
	output logic [31:0] port_out
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_MC1 = 2'b01,
		ST_MC2 = 2'b11
	} cpubt_state_e;

	cpubt_state_e st; // Execution phase
	cpubt_state_e next_st;
	logic [7:0] acc; // Accumulator
	logic [15:0] data_ptr; // Data pointer pair
	logic [15:0] prog_ctr; // Address of the pending instruction
	logic [7:0] status_word; // Carry, banks, parity, flags
	logic [7:0] ptr_regs [8]; // Pointer registers 0 and 1 of 4 banks
	logic [7:0] bitram [16]; // Bit-addressable internal RAM
	logic [31:0] port_s1, port_sync; // Pin synchroniser
	cpubt_pkg::cpubt_op_e cur_op; // Latched instruction
	logic [7:0] cur_bit;
	logic [7:0] cur_rel;
	logic cur_sel;
	logic taken_flag; // Last instruction was a taken branch
	logic [7:0] data_buf; // Byte fetched in the second cycle
	logic pend, pend2; // Memory strobe pipeline for capture
	logic [4:0] exec_cnt; // Cycles spent on the current instruction
	logic mc_end, slot_s1, slot_s4;
	logic busy, setup, apb_wr, rd_err;
	logic [31:0] rd_word;
	logic cur_external_data_move, cur_xwr, cur_cld, two_mc, rmw, last;
	logic src_bit, c_we, c_val, b_we, b_val, take;
	logic [15:0] next_ctr, branch_tgt, tbl_addr;
	logic [2:0] ptr_idx;

	assign busy = (st != ST_IDLE);
	assign setup = psel && !penable;
	assign apb_wr = psel && penable && pready && pwrite && !pslverr;
	assign ptr_idx = {status_word[cpubt_pkg::SW_BANK_LSB +: 2], cur_sel};

	// Instruction class decode
	assign cur_external_data_move = (cur_op inside {cpubt_pkg::OP_XRD_PTR,
		cpubt_pkg::OP_XWR_PTR, cpubt_pkg::OP_XRD_DP, cpubt_pkg::OP_XWR_DP});
	assign cur_xwr = (cur_op == cpubt_pkg::OP_XWR_PTR) ||
		(cur_op == cpubt_pkg::OP_XWR_DP);
	assign cur_cld = (cur_op == cpubt_pkg::OP_CLD_DP) ||
		(cur_op == cpubt_pkg::OP_CLD_CTR);
	assign two_mc = cur_external_data_move || cur_cld;
	assign rmw = (cur_op == cpubt_pkg::OP_INV_BIT) ||
		(cur_op == cpubt_pkg::OP_BR_B1_CLR);

	// Address arithmetic
	assign next_ctr = prog_ctr + 16'(cpubt_pkg::cpubt_op_len(cur_op));
	assign branch_tgt = next_ctr + {{8{cur_rel[7]}}, cur_rel};
	assign tbl_addr = ((cur_op == cpubt_pkg::OP_CLD_DP) ? data_ptr :
		next_ctr) + {8'h00, acc};

	// Machine cycle sequencer
	cpubt_mc_timer #(
		.CYCLE(cpubt_pkg::MC_CLKS)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.run(busy),
		.mc_end(mc_end),
		.slot_s1(slot_s1),
		.slot_s4(slot_s4)
	);

	// Port pins come from outside, two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_s1 <= '0;
			port_sync <= '0;
		end else begin
			port_s1 <= port_in;
			port_sync <= port_s1;
		end
	end

	// Direct bit read; pins for tests, latch for read-modify-write
	function automatic logic get_bit(input logic [7:0] a,
		input logic latch);
		logic [7:0] byte_v;
		byte_v = 8'h00;
		if (!a[7]) begin
			byte_v = bitram[a[6:3]];
		end else if (a[7:6] == 2'b10 && !a[3]) begin
			byte_v = latch ? port_out[{a[5:4], 3'b000} +: 8] :
				port_sync[{a[5:4], 3'b000} +: 8];
		end else if (a[7:3] == cpubt_pkg::SPEC_STATUS_WORD) begin
			byte_v = status_word;
		end else if (a[7:3] == cpubt_pkg::SPEC_ACC) begin
			byte_v = acc;
		end
		return byte_v[a[2:0]];
	endfunction : get_bit

	// Procedural on purpose: a continuous assignment of a function call
	// wakes only on its arguments, so a repeated instruction on the same
	// bit would see a stale source byte
	always_comb begin
		src_bit = get_bit(cur_bit, rmw);
	end

	// Boolean processor; no exclusive-or form exists
	always_comb begin
		c_we = 1'b0;
		c_val = 1'b0;
		b_we = 1'b0;
		b_val = 1'b0;
		take = 1'b0;
		case (cur_op)
			cpubt_pkg::OP_MOV_C_BIT: begin
				c_we = 1'b1;
				c_val = src_bit;
			end
			cpubt_pkg::OP_MOV_BIT_C: begin
				b_we = 1'b1;
				b_val = status_word[cpubt_pkg::SW_CARRY];
			end
			cpubt_pkg::OP_CLR_C: c_we = 1'b1;
			cpubt_pkg::OP_CLR_BIT: b_we = 1'b1;
			cpubt_pkg::OP_SET_C: begin
				c_we = 1'b1;
				c_val = 1'b1;
			end
			cpubt_pkg::OP_SET_BIT: begin
				b_we = 1'b1;
				b_val = 1'b1;
			end
			cpubt_pkg::OP_INV_C: begin
				c_we = 1'b1;
				c_val = !status_word[cpubt_pkg::SW_CARRY];
			end
			cpubt_pkg::OP_INV_BIT: begin
				b_we = 1'b1;
				b_val = !src_bit;
			end
			cpubt_pkg::OP_AND_C: begin
				c_we = 1'b1;
				c_val = status_word[cpubt_pkg::SW_CARRY] & src_bit;
			end
			cpubt_pkg::OP_AND_NC: begin
				c_we = 1'b1;
				c_val = status_word[cpubt_pkg::SW_CARRY] & !src_bit;
			end
			cpubt_pkg::OP_OR_C: begin
				c_we = 1'b1;
				c_val = status_word[cpubt_pkg::SW_CARRY] | src_bit;
			end
			cpubt_pkg::OP_OR_NC: begin
				c_we = 1'b1;
				c_val = status_word[cpubt_pkg::SW_CARRY] | !src_bit;
			end
			cpubt_pkg::OP_BR_C1: take = status_word[cpubt_pkg::SW_CARRY];
			cpubt_pkg::OP_BR_C0: take = !status_word[cpubt_pkg::SW_CARRY];
			cpubt_pkg::OP_BR_B1: take = src_bit;
			cpubt_pkg::OP_BR_B0: take = !src_bit;
			cpubt_pkg::OP_BR_B1_CLR: begin
				take = src_bit;
				b_we = src_bit;
			end
			default: take = 1'b0;
		endcase
	end

	// Commit point: end of the instruction's final machine cycle
	assign last = mc_end && (st == ST_MC2 || (st == ST_MC1 && !two_mc));

	// APB read mux, sampled in the setup cycle
	always_comb begin
		rd_err = 1'b0;
		rd_word = 32'h0000_0000;
		case (paddr)
			cpubt_pkg::OFS_CTRL: rd_word = {7'h00, cur_sel, cur_rel,
				cur_bit, 3'b000, cur_op};
			cpubt_pkg::OFS_ACC: rd_word = {24'h00_0000, acc};
			cpubt_pkg::OFS_DATA_PTR: rd_word = {16'h0000, data_ptr};
			cpubt_pkg::OFS_PROG_CTR: rd_word = {16'h0000, prog_ctr};
			cpubt_pkg::OFS_STATUS_WORD: rd_word = {24'h00_0000, status_word};
			cpubt_pkg::OFS_BUSY: rd_word = {30'h0000_0000, taken_flag, busy};
			cpubt_pkg::OFS_POINTERS: rd_word = {16'h0000,
				ptr_regs[{ptr_idx[2:1], 1'b1}], ptr_regs[{ptr_idx[2:1], 1'b0}]};
			cpubt_pkg::OFS_PORT: rd_word = port_out;
			default: begin
				if (paddr[7:4] == cpubt_pkg::OFS_BITRAM[7:4] &&
					paddr[1:0] == 2'b00) begin
					rd_word = {bitram[{paddr[3:2], 2'd3}],
						bitram[{paddr[3:2], 2'd2}],
						bitram[{paddr[3:2], 2'd1}],
						bitram[{paddr[3:2], 2'd0}]};
				end else begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	// APB answer: one wait-free access phase; writes refused while busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup && (rd_err || (pwrite &&
				(busy || paddr == cpubt_pkg::OFS_BUSY)));
			prdata <= (setup && !pwrite && !rd_err) ? rd_word : '0;
		end
	end

	// Instruction latch, loaded by a control word write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_op <= cpubt_pkg::OP_NOP;
			cur_bit <= 8'h00;
			cur_rel <= 8'h00;
			cur_sel <= 1'b0;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_CTRL) begin
			cur_op <= cpubt_pkg::cpubt_op_e'(pwdata[cpubt_pkg::CTRL_OP_LSB +: 5]);
			cur_bit <= pwdata[cpubt_pkg::CTRL_BIT_LSB +: 8];
			cur_rel <= pwdata[cpubt_pkg::CTRL_REL_LSB +: 8];
			cur_sel <= pwdata[cpubt_pkg::CTRL_SEL_BIT];
		end
	end

	// Phase sequence: external moves and table loads take two cycles
	always_comb begin
		next_st = st;
		case (st)
			ST_IDLE: if (apb_wr && paddr == cpubt_pkg::OFS_CTRL) next_st = ST_MC1;
			ST_MC1: if (mc_end) next_st = two_mc ? ST_MC2 : ST_IDLE;
			ST_MC2: if (mc_end) next_st = ST_IDLE;
			default: next_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// Code strobes at S1 and S4; the table read replaces the S1 fetch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_rd <= 1'b0;
			code_addr <= 16'h0000;
		end else begin
			code_rd <= (slot_s1 || slot_s4) &&
				!(st == ST_MC2 && cur_external_data_move);
			if (st == ST_MC2 && slot_s1 && cur_cld) begin
				code_addr <= tbl_addr;
			end else if (slot_s1 || slot_s4) begin
				code_addr <= slot_s4 ? prog_ctr + 16'h0001 : prog_ctr;
			end
		end
	end

	// External data strobes, only in the second machine cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xdata_rd <= 1'b0;
			xdata_wr <= 1'b0;
			xdata_addr <= 16'h0000;
			xdata_wdata <= 8'h00;
		end else begin
			xdata_rd <= st == ST_MC2 && slot_s1 && cur_external_data_move && !cur_xwr;
			xdata_wr <= st == ST_MC2 && slot_s1 && cur_xwr;
			if (st == ST_MC2 && slot_s1 && cur_external_data_move) begin
				xdata_addr <= (cur_op == cpubt_pkg::OP_XRD_DP ||
					cur_op == cpubt_pkg::OP_XWR_DP) ? data_ptr :
					{8'h00, ptr_regs[ptr_idx]};
				xdata_wdata <= acc;
			end
		end
	end

	// Data returns one cycle after its strobe; capture it then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= 1'b0;
			pend2 <= 1'b0;
			data_buf <= 8'h00;
		end else begin
			pend <= st == ST_MC2 && slot_s1;
			pend2 <= pend;
			if (pend2) begin
				data_buf <= cur_external_data_move ? xdata_rdata : code_rdata;
			end
		end
	end

	// Accumulator: only destination of external reads and table loads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= cpubt_pkg::ACC_RST;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_ACC) begin
			acc <= pwdata[7:0];
		end else if (last && two_mc && !cur_xwr) begin
			acc <= data_buf;
		end else if (last && b_we && cur_bit[7:3] == cpubt_pkg::SPEC_ACC) begin
			acc[cur_bit[2:0]] <= b_val;
		end
	end

	// Status word: carry updates first, then addressed bit writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_word <= cpubt_pkg::STATUS_WORD_RST;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_STATUS_WORD) begin
			status_word <= pwdata[7:0];
		end else if (last && c_we) begin
			status_word[cpubt_pkg::SW_CARRY] <= c_val;
		end else if (last && b_we &&
			cur_bit[7:3] == cpubt_pkg::SPEC_STATUS_WORD) begin
			status_word[cur_bit[2:0]] <= b_val;
		end
	end

	// Lower half of bit space lives in RAM bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) bitram[i] <= 8'h00;
		end else if (apb_wr && paddr[7:4] == cpubt_pkg::OFS_BITRAM[7:4]) begin
			for (int i = 0; i < 4; i++) begin
				bitram[{paddr[3:2], 2'(i)}] <= pwdata[8*i +: 8];
			end
		end else if (last && b_we && !cur_bit[7]) begin
			bitram[cur_bit[6:3]][cur_bit[2:0]] <= b_val;
		end
	end

	// Port latches; a bit write touches one line only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_out <= cpubt_pkg::PORT_RST;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_PORT) begin
			port_out <= pwdata;
		end else if (last && b_we && cur_bit[7:6] == 2'b10 && !cur_bit[3]) begin
			port_out[{cur_bit[5:4], cur_bit[2:0]}] <= b_val;
		end
	end

	// Pointer registers of the selected bank, software loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 8; i++) ptr_regs[i] <= 8'h00;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_POINTERS) begin
			ptr_regs[{ptr_idx[2:1], 1'b0}] <= pwdata[7:0];
			ptr_regs[{ptr_idx[2:1], 1'b1}] <= pwdata[15:8];
		end
	end

	// Data pointer pair, software loaded
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_ptr <= cpubt_pkg::DATA_PTR_RST;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_DATA_PTR) begin
			data_ptr <= pwdata[15:0];
		end
	end

	// Program counter: next instruction, or the branch target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_ctr <= cpubt_pkg::PROG_CTR_RST;
			taken_flag <= 1'b0;
		end else if (apb_wr && paddr == cpubt_pkg::OFS_PROG_CTR) begin
			prog_ctr <= pwdata[15:0];
		end else if (last) begin
			prog_ctr <= take ? branch_tgt : next_ctr;
			taken_flag <= take;
		end
	end

	// Cycle count of the running instruction, for checking only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exec_cnt <= '0;
		end else begin
			exec_cnt <= busy ? exec_cnt + 1'b1 : '0;
		end
	end

	ext_ptr_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		(xdata_rd || xdata_wr) && (cur_op == cpubt_pkg::OP_XRD_PTR ||
		cur_op == cpubt_pkg::OP_XWR_PTR) |-> xdata_addr[15:8] == 8'h00)
		else $error("pointer move drove a high address byte");
	ext_acc_src_a: assert property (@(posedge pclk) disable iff (!presetn)
		xdata_wr |-> xdata_wdata == acc && !xdata_rd)
		else $error("external write data is not the accumulator");
	tbl_dp_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		st == ST_MC2 && slot_s1 && cur_op == cpubt_pkg::OP_CLD_DP |=>
		code_rd && code_addr == data_ptr + {8'h00, acc})
		else $error("pointer table address wrong");
	tbl_ctr_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
		st == ST_MC2 && slot_s1 && cur_op == cpubt_pkg::OP_CLD_CTR |=>
		code_rd && code_addr == prog_ctr + 16'h0001 + {8'h00, acc})
		else $error("counter table address wrong");
	no_fetch_a: assert property (@(posedge pclk) disable iff (!presetn)
		st == ST_MC2 && cur_external_data_move |=> !code_rd)
		else $error("code fetch during external move second cycle");
	cycle_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		busy && next_st == ST_IDLE |-> exec_cnt ==
		(two_mc ? 5'd23 : 5'd11))
		else $error("instruction length in clocks wrong");
	port_single_a: assert property (@(posedge pclk) disable iff (!presetn)
		last && b_we |=> $onehot0(port_out ^ $past(port_out)))
		else $error("port bit write disturbed other lines");
	carry_and_a: assert property (@(posedge pclk) disable iff (!presetn)
		last && cur_op == cpubt_pkg::OP_AND_C |=> status_word[7] ==
		($past(status_word[7]) & $past(src_bit)))
		else $error("carry and result wrong");
	test_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		last && cur_op == cpubt_pkg::OP_BR_B1_CLR && src_bit |=>
		!src_bit && prog_ctr == $past(branch_tgt))
		else $error("test-and-clear did not clear or jump");
	untaken_a: assert property (@(posedge pclk) disable iff (!presetn)
		last && cur_op inside {cpubt_pkg::OP_BR_B0, cpubt_pkg::OP_BR_B1,
		cpubt_pkg::OP_BR_B1_CLR} && !take |=> prog_ctr == $past(next_ctr)
		&& status_word == $past(status_word) && !taken_flag)
		else $error("untaken branch changed state");

endmodule : cpubt_core

// *** rtl/cpubt_mc_timer.sv ***
`timescale 1ns/1ps
// Machine cycle sequencer: six states of two clocks each
module cpubt_mc_timer #(
	parameter int unsigned CYCLE = cpubt_pkg::MC_CLKS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	output logic mc_end,
	output logic slot_s1,
	output logic slot_s4
);

	// Position inside the machine cycle, held at zero while idle
	logic [cpubt_pkg::CNT_W-1:0] cnt;

	// Wraps so back to back machine cycles keep their phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (!run || cnt == cpubt_pkg::CNT_W'(CYCLE - 1)) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	assign mc_end = run && (cnt == cpubt_pkg::CNT_W'(CYCLE - 1));
	assign slot_s1 = run && (cnt == '0);
	assign slot_s4 = run && (cnt == cpubt_pkg::CNT_W'(cpubt_pkg::S4_START));

endmodule : cpubt_mc_timer

// *** rtl/cpubt_pkg.sv ***
package cpubt_pkg;

	// Machine cycle timing in oscillator (pclk) periods
	localparam int unsigned STATE_CLKS = 2;
	localparam int unsigned STATES_PER_MC = 6;
	localparam int unsigned MC_CLKS = STATE_CLKS * STATES_PER_MC;
	localparam int unsigned CNT_W = $clog2(MC_CLKS);
	// Counter value at the start of state S4
	localparam int unsigned S4_START = STATE_CLKS * 3;

	// APB byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACC = 8'h04;
	localparam logic [7:0] OFS_DATA_PTR = 8'h08;
	localparam logic [7:0] OFS_PROG_CTR = 8'h0C;
	localparam logic [7:0] OFS_STATUS_WORD = 8'h10;
	localparam logic [7:0] OFS_BUSY = 8'h14;
	localparam logic [7:0] OFS_POINTERS = 8'h18;
	localparam logic [7:0] OFS_PORT = 8'h1C;
	localparam logic [7:0] OFS_BITRAM = 8'h20;

	// Control word field positions
	localparam int unsigned CTRL_OP_LSB = 0;
	localparam int unsigned CTRL_BIT_LSB = 8;
	localparam int unsigned CTRL_REL_LSB = 16;
	localparam int unsigned CTRL_SEL_BIT = 24;

	// Status word fields
	localparam int unsigned SW_CARRY = 7;
	localparam int unsigned SW_BANK_LSB = 3;

	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] DATA_PTR_RST = 16'h0000;
	localparam logic [15:0] PROG_CTR_RST = 16'h0000;
	localparam logic [7:0] STATUS_WORD_RST = 8'h00;
	localparam logic [31:0] PORT_RST = 32'hFFFF_FFFF;

	// Bit space: byte bases (bit address bits 7:3) above the lower half
	localparam logic [4:0] SPEC_STATUS_WORD = 5'h1A;
	localparam logic [4:0] SPEC_ACC = 5'h1C;

	// Operation codes written into the control word
	typedef enum logic [4:0] {
		OP_NOP = 5'h00,
		OP_XRD_PTR = 5'h01,
		OP_XWR_PTR = 5'h02,
		OP_XRD_DP = 5'h03,
		OP_XWR_DP = 5'h04,
		OP_CLD_DP = 5'h05,
		OP_CLD_CTR = 5'h06,
		OP_MOV_C_BIT = 5'h07,
		OP_MOV_BIT_C = 5'h08,
		OP_CLR_C = 5'h09,
		OP_CLR_BIT = 5'h0A,
		OP_SET_C = 5'h0B,
		OP_SET_BIT = 5'h0C,
		OP_INV_C = 5'h0D,
		OP_INV_BIT = 5'h0E,
		OP_AND_C = 5'h0F,
		OP_AND_NC = 5'h10,
		OP_OR_C = 5'h11,
		OP_OR_NC = 5'h12,
		OP_BR_C1 = 5'h13,
		OP_BR_C0 = 5'h14,
		OP_BR_B1 = 5'h15,
		OP_BR_B0 = 5'h16,
		OP_BR_B1_CLR = 5'h17
	} cpubt_op_e;

	// Instruction length in code bytes
	function automatic logic [1:0] cpubt_op_len(input cpubt_op_e op);
		case (op)
			OP_BR_B1, OP_BR_B0, OP_BR_B1_CLR: return 2'd3;
			OP_MOV_C_BIT, OP_MOV_BIT_C, OP_CLR_BIT, OP_SET_BIT,
			OP_INV_BIT, OP_AND_C, OP_AND_NC, OP_OR_C, OP_OR_NC,
			OP_BR_C1, OP_BR_C0: return 2'd2;
			default: return 2'd1;
		endcase
	endfunction : cpubt_op_len

endpackage : cpubt_pkg

// *** tb/cpubt_core_tb_top.sv ***
`timescale 1ns/1ps
// Directed bench: APB register access, instructions started through CTRL
module cpubt_core_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, code_rdata, xdata_wdata, xdata_rdata;
	logic [31:0] pwdata, prdata, port_in, port_out;
	logic [15:0] code_addr, xdata_addr;
	logic code_rd, xdata_rd, xdata_wr;
	logic [31:0] r;
	logic e;
	int fails, checks, cyc, nfet, nxa;
	// Bit operation sequence and the status word after each step
	cpubt_pkg::cpubt_op_e bo[12] = '{cpubt_pkg::OP_AND_NC, cpubt_pkg::OP_OR_C,
		cpubt_pkg::OP_AND_C, cpubt_pkg::OP_OR_NC, cpubt_pkg::OP_MOV_C_BIT,
		cpubt_pkg::OP_INV_C, cpubt_pkg::OP_CLR_BIT, cpubt_pkg::OP_SET_BIT,
		cpubt_pkg::OP_INV_BIT, cpubt_pkg::OP_SET_C, cpubt_pkg::OP_CLR_C,
		cpubt_pkg::OP_MOV_C_BIT};
	logic [7:0] bb[12] = '{5, 5, 'h90, 'h90, 'h90, 0, 'hD7, 'hD1, 'hD0, 0, 0, 5};
	logic [7:0] bs[12] = '{0, 'h80, 0, 'h80, 0, 'h80, 0, 2, 3, 'h83, 3, 'h83};
	// Branch sequence: op, bit, offset, target from pc 1000, taken
	cpubt_pkg::cpubt_op_e jo[8] = '{cpubt_pkg::OP_BR_C1, cpubt_pkg::OP_BR_C0,
		cpubt_pkg::OP_BR_B1, cpubt_pkg::OP_BR_B0, cpubt_pkg::OP_BR_B1_CLR,
		cpubt_pkg::OP_BR_B1_CLR, cpubt_pkg::OP_BR_B0, cpubt_pkg::OP_BR_B1};
	logic [7:0] jb[8] = '{0, 0, 5, 5, 5, 5, 5, 'hD1};
	logic [7:0] jr[8] = '{'h7F, 'h10, 'h80, 1, 'hFE, 'hFE, 'hFF, 4};
	logic [15:0] jp[8] = '{'h1081, 'h1002, 'h0F83, 'h1003, 'h1001, 'h1003,
		'h1002, 'h1007};
	logic jt[8] = '{1, 0, 1, 0, 1, 0, 1, 1};

	cpubt_core uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.code_addr(code_addr), .code_rd(code_rd), .code_rdata(code_rdata),
		.xdata_addr(xdata_addr), .xdata_wdata(xdata_wdata),
		.xdata_rd(xdata_rd), .xdata_wr(xdata_wr), .xdata_rdata(xdata_rdata),
		.port_in(port_in), .port_out(port_out));

	cpubt_mem_model mem (.pclk(pclk), .code_addr(code_addr),
		.code_rd(code_rd), .code_rdata(code_rdata), .xdata_addr(xdata_addr),
		.xdata_wdata(xdata_wdata), .xdata_rd(xdata_rd), .xdata_wr(xdata_wr),
		.xdata_rdata(xdata_rdata));

	// 100 MHz clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Cycle count and strobe counts, used for machine cycle timing
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (code_rd === 1'b1) begin
			nfet <= nfet + 1;
		end
		if (xdata_rd === 1'b1 || xdata_wr === 1'b1) begin
			nxa <= nxa + 1;
		end
	end

	// Expected program byte, same pattern the memory model serves
	function automatic logic [31:0] cb(input logic [15:0] a);
		return {24'h0, a[7:0] ^ a[15:8] ^ 8'h5A};
	endfunction : cb

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic err);
		apb(a, 1'b1, d);
		chk({31'h0, e}, {31'h0, err});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0);
		chk(r, exp);
	endtask : rd

	// Start one instruction, poll busy, check duration and strobes
	task automatic exec(input cpubt_pkg::cpubt_op_e op, input logic [7:0] b,
		input logic [7:0] rel, input logic sel, input int mcs, input int nf,
		input int nx);
		int t0;
		wr(cpubt_pkg::OFS_CTRL, {7'h00, sel, rel, b, 3'h0, op}, 1'b0);
		t0 = cyc;
		nfet = 0;
		nxa = 0;
		do apb(cpubt_pkg::OFS_BUSY, 1'b0, 32'h0); while (r[0] !== 1'b0);
		chk(32'(cyc - t0 >= 12 * mcs && cyc - t0 <= 12 * mcs + 4), 1);
		chk(32'(nfet), 32'(nf));
		chk(32'(nxa), 32'(nx));
	endtask : exec

	task automatic report_and_stop();
		if (fails == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	// Guard against a hang; the whole sequence needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		report_and_stop();
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite} = 3'b000;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		port_in = 32'hA5A5_5A5A;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(cpubt_pkg::OFS_PORT, 32'hFFFF_FFFF);
		// External moves through data pointer and through R1, high byte 00
		wr(cpubt_pkg::OFS_ACC, 32'h0000_00A5, 1'b0);
		wr(cpubt_pkg::OFS_DATA_PTR, 32'h0000_1234, 1'b0);
		exec(cpubt_pkg::OP_XWR_DP, 0, 0, 0, 2, 2, 1);
		wr(cpubt_pkg::OFS_ACC, 32'h0000_0000, 1'b0);
		exec(cpubt_pkg::OP_XRD_DP, 0, 0, 0, 2, 2, 1);
		rd(cpubt_pkg::OFS_ACC, 32'h0000_00A5);
		wr(cpubt_pkg::OFS_POINTERS, 32'h0000_3400, 1'b0);
		wr(cpubt_pkg::OFS_ACC, 32'h0000_003C, 1'b0);
		exec(cpubt_pkg::OP_XWR_PTR, 0, 0, 1, 2, 2, 1);
		wr(cpubt_pkg::OFS_DATA_PTR, 32'h0000_0034, 1'b0);
		wr(cpubt_pkg::OFS_ACC, 32'h0000_0000, 1'b0);
		exec(cpubt_pkg::OP_XRD_DP, 0, 0, 0, 2, 2, 1);
		rd(cpubt_pkg::OFS_ACC, 32'h0000_003C);
		rd(cpubt_pkg::OFS_POINTERS, 32'h0000_3400);
		wr(cpubt_pkg::OFS_ACC, 32'h0000_0000, 1'b0);
		exec(cpubt_pkg::OP_XRD_PTR, 0, 0, 1, 2, 2, 1);
		rd(cpubt_pkg::OFS_ACC, 32'h0000_003C);
		// Table loads, the data pointer sum carrying into the high byte
		wr(cpubt_pkg::OFS_ACC, 32'h0000_00F0, 1'b0);
		wr(cpubt_pkg::OFS_DATA_PTR, 32'h0000_2020, 1'b0);
		exec(cpubt_pkg::OP_CLD_DP, 0, 0, 0, 2, 4, 0);
		rd(cpubt_pkg::OFS_ACC, cb(16'h2110));
		wr(cpubt_pkg::OFS_PROG_CTR, 32'h0000_0100, 1'b0);
		wr(cpubt_pkg::OFS_ACC, 32'h0000_0005, 1'b0);
		exec(cpubt_pkg::OP_CLD_CTR, 0, 0, 0, 2, 4, 0);
		rd(cpubt_pkg::OFS_ACC, cb(16'h0106));
		rd(cpubt_pkg::OFS_PROG_CTR, 32'h0000_0101);
		// Carry to one port line, then to a RAM bit
		exec(cpubt_pkg::OP_NOP, 0, 0, 0, 1, 2, 0);
		exec(cpubt_pkg::OP_MOV_BIT_C, 8'h91, 0, 0, 1, 2, 0);
		chk(port_out, 32'hFFFF_FDFF);
		exec(cpubt_pkg::OP_SET_C, 0, 0, 0, 1, 2, 0);
		exec(cpubt_pkg::OP_MOV_BIT_C, 8'h05, 0, 0, 1, 2, 0);
		rd(cpubt_pkg::OFS_BITRAM, 32'h0000_0020);
		for (int i = 0; i < 12; i++) begin
			exec(bo[i], bb[i], 0, 0, 1, 2, 0);
			rd(cpubt_pkg::OFS_STATUS_WORD, {24'h0, bs[i]});
		end
		// Bit-test branches over both signs of offset
		for (int i = 0; i < 8; i++) begin
			wr(cpubt_pkg::OFS_PROG_CTR, 32'h0000_1000, 1'b0);
			exec(jo[i], jb[i], jr[i], 0, 1, 2, 0);
			rd(cpubt_pkg::OFS_PROG_CTR, {16'h0, jp[i]});
			rd(cpubt_pkg::OFS_BUSY, {30'h0, jt[i], 1'b0});
		end
		rd(cpubt_pkg::OFS_BITRAM, 32'h0000_0000);
		rd(cpubt_pkg::OFS_STATUS_WORD, 32'h0000_0083);
		// Refused accesses: busy write, read-only word, unmapped place
		wr(cpubt_pkg::OFS_CTRL, 32'h0000_0000, 1'b0);
		wr(cpubt_pkg::OFS_ACC, 32'h0000_0077, 1'b1);
		wr(cpubt_pkg::OFS_BUSY, 32'h0000_0000, 1'b1);
		apb(8'hFC, 1'b0, 32'h0);
		chk({r[30:0], e}, 32'h0000_0001);
		repeat (16) @(posedge pclk);
		rd(cpubt_pkg::OFS_ACC, cb(16'h0106));
		report_and_stop();
	end
endmodule : cpubt_core_tb_top

// *** tb/cpubt_mem_model.sv ***
`timescale 1ns/1ps
// Program and external data memories, both with one-cycle read latency
module cpubt_mem_model (
	input wire logic pclk,
	input wire logic [15:0] code_addr,
	input wire logic code_rd,
	output logic [7:0] code_rdata,
	input wire logic [15:0] xdata_addr,
	input wire logic [7:0] xdata_wdata,
	input wire logic xdata_rd,
	input wire logic xdata_wr,
	output logic [7:0] xdata_rdata
);
	// Full 16-bit space, so a wrong high address byte cannot alias
	logic [7:0] xmem [0:65535];

	initial begin
		code_rdata = 8'h00;
		xdata_rdata = 8'h00;
	end

	// Valid data only after a strobe; otherwise it toggles every cycle
	always @(posedge pclk) begin
		if (code_rd === 1'b1) begin
			code_rdata <= code_addr[7:0] ^ code_addr[15:8] ^ 8'h5A;
		end else begin
			code_rdata <= ~code_rdata;
		end
		if (xdata_rd === 1'b1) begin
			xdata_rdata <= xmem[xdata_addr];
		end else begin
			xdata_rdata <= ~xdata_rdata;
		end
		if (xdata_wr === 1'b1) begin
			xmem[xdata_addr] <= xdata_wdata;
		end
	end
endmodule : cpubt_mem_model
